/* rxs_pkg.sv */
// Constants shared by the receive status and data block.
// Assumes a host that reaches the registers over a four-wire serial port.
// How it works
// [R1] Full A enable bit lets a channel A full event drive the interrupt pin.
// [R2] A whole byte or an end of frame moves received bits into the byte register.
// [R3] Each load sets the channel all-valid flag only when eight bits are valid.
// [R4] All-valid flags never take part in the interrupt.
// [R5] A load while the previous byte is still unread flags a flow violation.
// [R6] Reading the data byte when nothing new is held flags a flow violation.
// [R7] Reading the status byte clears flow and end-of-frame flags of both channels.
// [R8] After reception starts, one invalid bit time more than the programmed gap flags end of frame.
// [R9] Each load of a channel byte sets that channel's full flag.
// [R10] Flags are set and readable whatever the interrupt enables say.
// [R11] Status reads as zero unless the device is in receive mode.
// [R12] Writes to the status byte change no flag.
// [R13] First received bit of channel A lands in bit 0, then upward.
// [R14] Channel A data byte is eight bits, read only, reset to zero.
// [R15] Gap length zero ends the frame at the first invalid bit after a valid one.
// [R16] Interrupt pin asserts while an enabled full, flow or frame-end flag is pending in receive mode.
// [R17] Host reads each byte before the next load and reads status to clear events.
package rxs_pkg;

    localparam int          ADDR_W         = 6;
    localparam int          BYTE_W         = 8;
    localparam int          CNT_W          = 3;
    localparam int          GAP_W          = 4;

    localparam logic [5:0]  ADDR_RX_STATUS = 6'h08;
    localparam logic [5:0]  ADDR_RX_DATA_A = 6'h09;

    localparam logic [7:0]  RX_STATUS_RST  = 8'h00;
    localparam logic [7:0]  RX_DATA_A_RST  = 8'h00;

    localparam int          ST_FULL_A      = 0;
    localparam int          ST_EOF_A       = 1;
    localparam int          ST_FLOW_A      = 2;
    localparam int          ST_VALID_A     = 3;
    localparam int          ST_FULL_B      = 4;
    localparam int          ST_EOF_B       = 5;
    localparam int          ST_FLOW_B      = 6;
    localparam int          ST_VALID_B     = 7;

    // Bits of the status byte that may raise the interrupt
    localparam logic [7:0]  IRQ_SRC_MASK   = 8'h77;

    localparam logic [1:0]  IRQ_OPEN_SRC   = 2'h3;
    localparam logic [1:0]  IRQ_OPEN_DRAIN = 2'h2;
    localparam logic [1:0]  IRQ_CMOS       = 2'h1;
    localparam logic [1:0]  IRQ_CMOS_INV   = 2'h0;

    localparam int          SPI_WR_BIT     = 7;
    localparam logic [2:0]  SPI_LAST_BIT   = 3'h7;

    typedef enum logic [1:0] {
        SPI_IDLE = 2'h0,
        SPI_ADDR = 2'h1,
        SPI_DATA = 2'h3,
        SPI_DONE = 2'h2
    } rxs_spi_e;

endpackage

/* rxs_sync.sv */
// Two-flop synchroniser for levels and toggles.
// Assumes each bit is a level that may change at any time relative to clk.
`timescale 1ns/10ps
module rxs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

/* rxs_chan.sv */
// One receive channel on the bit clock: assembles bytes, times frame gaps.
// Assumes the correlator bit clock runs freely and bit_valid is on that clock.
`timescale 1ns/10ps
module rxs_chan
    import rxs_pkg::*;
(
    input  wire logic               bit_clk,
    input  wire logic               rst,
    input  wire logic               bit_valid,
    input  wire logic               bit_data,
    input  wire logic [CNT_W-1:0]   eof_len,
    output logic      [BYTE_W-1:0]  out_byte,
    output logic                    out_all_valid,
    output logic                    load_tgl,
    output logic                    eof_tgl
);
    logic [BYTE_W-1:0] shreg;
    logic [BYTE_W-1:0] vmask;
    logic [CNT_W-1:0]  cnt;
    logic [GAP_W-1:0]  gap;
    logic              started;

    wire [BYTE_W-1:0] next_shreg = shreg | (BYTE_W'(bit_data) << cnt); // [R13]
    wire [BYTE_W-1:0] next_vmask = vmask | (BYTE_W'(1'b1) << cnt);
    wire              byte_done  = bit_valid && (cnt == SPI_LAST_BIT);
    wire [GAP_W-1:0]  next_gap   = gap + GAP_W'(1);
    // Gap must exceed the length, so zero ends at the first invalid bit
    wire              gap_end    = !bit_valid && started
                                   && (next_gap > {1'b0, eof_len}); // [R8] [R15]
    wire              part_load  = gap_end && (vmask != '0);         // [R2]

    always_ff @(posedge bit_clk or posedge rst) begin
        if (rst) begin
            shreg         <= '0;
            vmask         <= '0;
            cnt           <= '0;
            gap           <= '0;
            started       <= 1'b0;
            out_byte      <= '0;
            out_all_valid <= 1'b0;
            load_tgl      <= 1'b0;
            eof_tgl       <= 1'b0;
        end else if (byte_done) begin
            out_byte      <= next_shreg;                     // [R2]
            out_all_valid <= &next_vmask;                    // [R3]
            load_tgl      <= ~load_tgl;
            shreg         <= '0;
            vmask         <= '0;
            cnt           <= '0;
            gap           <= '0;
            started       <= 1'b1;
        end else if (bit_valid) begin
            shreg   <= next_shreg;
            vmask   <= next_vmask;
            cnt     <= cnt + CNT_W'(1);
            gap     <= '0;
            started <= 1'b1;
        end else if (gap_end) begin
            eof_tgl <= ~eof_tgl;                             // [R8]
            if (part_load) begin
                out_byte      <= shreg;                      // [R2]
                out_all_valid <= &vmask;                     // [R3]
                load_tgl      <= ~load_tgl;
            end
            shreg   <= '0;
            vmask   <= '0;
            cnt     <= '0;
            gap     <= '0;
            started <= 1'b0;
        end else if (started) begin
            gap <= next_gap;
        end
    end
endmodule

/* rxs_top.sv */
// Receive status and channel A data registers behind a serial register port.
// Assumes tx/rx enables, interrupt enables, pin select and gap length come
// from other register logic on ref_clk; bit inputs come on rx_bit_clk.
`timescale 1ns/10ps
module rxs_top
    import rxs_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              rx_bit_clk,
    input  wire logic              chan_a_bit_valid,
    input  wire logic              chan_a_bit_data,
    input  wire logic              chan_b_bit_valid,
    input  wire logic              chan_b_bit_data,
    input  wire logic [CNT_W-1:0]  eof_len,
    input  wire logic              tx_enable,
    input  wire logic              rx_enable,
    input  wire logic [7:0]        rx_int_enable,
    input  wire logic [1:0]        irq_pin_sel,
    input  wire logic              spi_sck,
    input  wire logic              spi_csn,
    input  wire logic              spi_mosi,
    output logic                   spi_miso,
    output logic                   spi_miso_oe,
    output logic                   irq_out,
    output logic                   irq_oe
);
    import rxs_pkg::*;

    // Flag update: a hardware set always beats a clear in the same cycle
    function automatic logic flag_next(input logic set, input logic cur,
                                       input logic clr);
        flag_next = set | (cur & ~clr);
    endfunction

    // ---------------- Bit clock side ----------------
    logic [CNT_W-1:0]  eof_len_bit;
    logic [BYTE_W-1:0] byte_a;
    logic [BYTE_W-1:0] byte_b;
    logic              all_a;
    logic              all_b;
    logic              load_tgl_a;
    logic              load_tgl_b;
    logic              eof_tgl_a;
    logic              eof_tgl_b;

    // Gap length is quasi-static; software changes it between frames only
    rxs_sync #(.W(CNT_W)) u_len_sync (
        .clk (rx_bit_clk),
        .rst (rst),
        .d   (eof_len),
        .q   (eof_len_bit)
    );

    rxs_chan u_chan_a (
        .bit_clk       (rx_bit_clk),
        .rst           (rst),
        .bit_valid     (chan_a_bit_valid),
        .bit_data      (chan_a_bit_data),
        .eof_len       (eof_len_bit),
        .out_byte      (byte_a),
        .out_all_valid (all_a),
        .load_tgl      (load_tgl_a),
        .eof_tgl       (eof_tgl_a)
    );

    rxs_chan u_chan_b (
        .bit_clk       (rx_bit_clk),
        .rst           (rst),
        .bit_valid     (chan_b_bit_valid),
        .bit_data      (chan_b_bit_data),
        .eof_len       (eof_len_bit),
        .out_byte      (byte_b),
        .out_all_valid (all_b),
        .load_tgl      (load_tgl_b),
        .eof_tgl       (eof_tgl_b)
    );

    // ---------------- Crossing into ref_clk ----------------
    // Byte and all-valid stay frozen for a full bit time after each toggle,
    // far longer than the two-flop delay, so they are read without a sync.
    logic [3:0] tgl_s;
    logic [3:0] tgl_d;

    rxs_sync #(.W(4)) u_tgl_sync (
        .clk (ref_clk),
        .rst (rst),
        .d   ({eof_tgl_b, load_tgl_b, eof_tgl_a, load_tgl_a}),
        .q   (tgl_s)
    );

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tgl_d <= '0;
        end else begin
            tgl_d <= tgl_s;
        end
    end

    wire load_a = tgl_s[0] ^ tgl_d[0];
    wire eof_a  = tgl_s[1] ^ tgl_d[1];
    wire load_b = tgl_s[2] ^ tgl_d[2];
    wire eof_b  = tgl_s[3] ^ tgl_d[3];

    // ---------------- Serial register port ----------------
    // Pins are sampled on ref_clk; sck is slow enough for edge detection.
    logic [2:0] pin_s;
    logic       sck_d;

    // Select crosses inverted so the cleared sync reads as deselected
    // and miso is not driven on the way out of reset
    rxs_sync #(.W(3)) u_pin_sync (
        .clk (ref_clk),
        .rst (rst),
        .d   ({spi_mosi, ~spi_csn, spi_sck}),
        .q   (pin_s)
    );

    wire s_sck  = pin_s[0];
    wire s_csn  = ~pin_s[1];
    wire s_mosi = pin_s[2];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sck_d <= 1'b0;
        end else begin
            sck_d <= s_sck;
        end
    end

    wire sck_rise = s_sck & ~sck_d & ~s_csn;
    wire sck_fall = ~s_sck & sck_d & ~s_csn;

    rxs_spi_e         state;
    rxs_spi_e         next_state;
    logic [CNT_W-1:0] bit_cnt;
    logic [7:0]       shift_in;
    logic [7:0]       shift_out;

    wire [7:0]        cmd_byte  = {shift_in[6:0], s_mosi};
    wire [ADDR_W-1:0] cmd_addr  = cmd_byte[ADDR_W-1:0];
    wire              cmd_wr    = cmd_byte[SPI_WR_BIT];
    wire              last_bit  = sck_rise && (bit_cnt == SPI_LAST_BIT);
    wire              addr_done = (state == SPI_ADDR) && last_bit;
    // Writes are decoded as nothing here, so the status byte ignores them
    wire              rd_status = addr_done && !cmd_wr
                                  && (cmd_addr == ADDR_RX_STATUS); // [R12]
    wire              rd_data_a = addr_done && !cmd_wr
                                  && (cmd_addr == ADDR_RX_DATA_A);

    always_comb begin
        next_state = state;
        case (state)
            SPI_IDLE: if (!s_csn) next_state = SPI_ADDR;
            SPI_ADDR: if (last_bit) next_state = SPI_DATA;
            SPI_DATA: if (last_bit) next_state = SPI_DONE;
            SPI_DONE: next_state = SPI_DONE;
            default:  next_state = SPI_IDLE;
        endcase
        if (s_csn) begin
            next_state = SPI_IDLE;
        end
    end

    // ---------------- Status and data registers ----------------
    logic              full_a;
    logic              eofl_a;
    logic              flow_a;
    logic              valid_a;
    logic              full_b;
    logic              eofl_b;
    logic              flow_b;
    logic              valid_b;
    logic              unread_a;
    logic              unread_b;
    logic [BYTE_W-1:0] data_a;

    wire rx_mode = rx_enable & ~tx_enable;

    wire [7:0] status_raw = {valid_b, flow_b, eofl_b, full_b,
                             valid_a, flow_a, eofl_a, full_a};
    wire [7:0] status_word = rx_mode ? status_raw : 8'h00;          // [R11]

    wire [7:0] read_word = (cmd_addr == ADDR_RX_STATUS) ? status_word :
                           (cmd_addr == ADDR_RX_DATA_A) ? data_a : 8'h00;

    wire next_full_a   = flag_next(load_a, full_a, rd_data_a);     // [R9]
    wire next_full_b   = flag_next(load_b, full_b, 1'b0);          // [R9]
    wire next_eofl_a   = flag_next(eof_a, eofl_a, rd_status);      // [R7] [R8]
    wire next_eofl_b   = flag_next(eof_b, eofl_b, rd_status);      // [R7] [R8]
    wire ovf_a         = load_a & unread_a;                         // [R5]
    wire udf_a         = rd_data_a & ~unread_a;                     // [R6]
    wire next_flow_a   = flag_next(ovf_a | udf_a, flow_a, rd_status); // [R7]
    wire next_flow_b   = flag_next(load_b & unread_b, flow_b, rd_status); // [R5]
    wire next_unread_a = flag_next(load_a, unread_a, rd_data_a);
    // Channel B data is not mapped here, so its byte is never consumed
    wire next_unread_b = load_b | unread_b;

    // Enables only gate the pin; flags run regardless
    wire irq_pend = |(status_word & rx_int_enable & IRQ_SRC_MASK);  // [R1] [R4] [R10] [R16]

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            full_a   <= RX_STATUS_RST[ST_FULL_A];
            eofl_a   <= RX_STATUS_RST[ST_EOF_A];
            flow_a   <= RX_STATUS_RST[ST_FLOW_A];
            valid_a  <= RX_STATUS_RST[ST_VALID_A];
            full_b   <= RX_STATUS_RST[ST_FULL_B];
            eofl_b   <= RX_STATUS_RST[ST_EOF_B];
            flow_b   <= RX_STATUS_RST[ST_FLOW_B];
            valid_b  <= RX_STATUS_RST[ST_VALID_B];
            unread_a <= 1'b0;
            unread_b <= 1'b0;
            data_a   <= RX_DATA_A_RST;                              // [R14]
        end else begin
            full_a   <= next_full_a;
            eofl_a   <= next_eofl_a;
            flow_a   <= next_flow_a;
            full_b   <= next_full_b;
            eofl_b   <= next_eofl_b;
            flow_b   <= next_flow_b;
            unread_a <= next_unread_a;
            unread_b <= next_unread_b;
            if (load_a) begin
                valid_a <= all_a;                                   // [R3]
                data_a  <= byte_a;                                  // [R2] [R13]
            end
            if (load_b) begin
                valid_b <= all_b;                                   // [R3]
            end
        end
    end

    // ---------------- Serial shifter ----------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state       <= SPI_IDLE;
            bit_cnt     <= '0;
            shift_in    <= 8'h00;
            shift_out   <= 8'h00;
            spi_miso    <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else begin
            state       <= next_state;
            spi_miso_oe <= ~s_csn;
            if (s_csn) begin
                bit_cnt <= '0;
            end else if (sck_rise) begin
                bit_cnt  <= bit_cnt + CNT_W'(1);
                shift_in <= cmd_byte;
            end
            // First data bit is ready long before the next rising sck
            if (addr_done) begin
                shift_out <= cmd_wr ? 8'h00 : read_word;
                spi_miso  <= cmd_wr ? 1'b0 : read_word[7];
            end else if (sck_fall && state == SPI_DATA) begin
                // Fall before the ninth rise must still present bit 7
                shift_out <= {shift_out[6:0], 1'b0};
                spi_miso  <= shift_out[7];
            end
        end
    end

    // ---------------- Interrupt pin ----------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_out <= 1'b0;
            irq_oe  <= 1'b0;
        end else begin
            case (irq_pin_sel)
                IRQ_OPEN_SRC: begin
                    irq_out <= 1'b1;
                    irq_oe  <= irq_pend;                            // [R16]
                end
                IRQ_OPEN_DRAIN: begin
                    irq_out <= 1'b0;
                    irq_oe  <= irq_pend;                            // [R16]
                end
                IRQ_CMOS: begin
                    irq_out <= irq_pend;                            // [R16]
                    irq_oe  <= 1'b1;
                end
                IRQ_CMOS_INV: begin
                    irq_out <= ~irq_pend;                           // [R16]
                    irq_oe  <= 1'b1;
                end
                default: begin
                    irq_out <= 1'b0;
                    irq_oe  <= 1'b0;
                end
            endcase
        end
    end
endmodule

/* rxs_chk.sv */
// Pin-level assertions for the receive status block.
// Assumes it is bound onto rxs_top and sees only that module's ports.
`timescale 1ns/10ps
module rxs_chk (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        rx_bit_clk,
    input wire logic        tx_enable,
    input wire logic        rx_enable,
    input wire logic [7:0]  rx_int_enable,
    input wire logic [1:0]  irq_pin_sel,
    input wire logic        spi_csn,
    input wire logic        spi_miso_oe,
    input wire logic        irq_out,
    input wire logic        irq_oe
);
    wire rxm = rx_enable && !tx_enable;
    // Asserted in the sense of the selected drive mode
    wire act = irq_pin_sel[1] ? irq_oe : (irq_out == irq_pin_sel[0]);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_no_rx;
        (!rxm && $stable(irq_pin_sel))[*4];
    endsequence
    sequence s_no_en;
        ((rx_int_enable & 8'h77) == 8'h00 && $stable(irq_pin_sel))[*4];
    endsequence
    sequence s_csn_idle;
        spi_csn[*6];
    endsequence
    // Two cycles of slack: the gated status may be registered before the pin
    property p_cause;
        act && $stable(irq_pin_sel) |-> ($past(rxm) || $past(rxm, 2))
            && ((($past(rx_int_enable) | $past(rx_int_enable, 2)) & 8'h77) != 8'h00);
    endproperty

    a_mode_gate: assert property (s_no_rx |-> !act)
        else $error("irq active outside receive mode");
    a_enable_gate: assert property (s_no_en |-> !act)
        else $error("irq active with no source enabled");
    a_irq_cause: assert property (p_cause)
        else $error("irq active without enabled cause");
    a_cmos_drive: assert property (!irq_pin_sel[1] ##1 !irq_pin_sel[1] |-> irq_oe)
        else $error("irq pin not driven in push-pull mode");
    a_open_level: assert property (irq_pin_sel[1] && $stable(irq_pin_sel) && irq_oe
        |-> irq_out == irq_pin_sel[0])
        else $error("irq level wrong in open mode");
    a_oe_rise: assert property ($rose(spi_csn) |-> ##[1:5] !spi_miso_oe)
        else $error("miso still driven after deselect");
    a_oe_fall: assert property ($fell(spi_csn) |-> ##[1:5] spi_miso_oe)
        else $error("miso not driven after select");
    a_oe_quiet: assert property (s_csn_idle |-> !spi_miso_oe)
        else $error("miso driven while deselected");
endmodule

bind rxs_top rxs_chk rxs_chk_i (.ref_clk, .rst, .rx_bit_clk, .tx_enable, .rx_enable,
    .rx_int_enable, .irq_pin_sel, .spi_csn, .spi_miso_oe, .irq_out, .irq_oe);

/* rxs_host.sv */
// Host controller model driving the serial register port.
// Assumes one command byte and one data byte per select, mode 0.
`timescale 1ns/10ps
module rxs_host (
    input  wire logic ref_clk,
    input  wire logic spi_miso,
    input  wire logic spi_miso_oe,
    output logic      spi_sck,
    output logic      spi_csn,
    output logic      spi_mosi
);
    localparam int HALF = 8;
    initial begin
        spi_sck = 1'b0;
        spi_csn = 1'b1;
        spi_mosi = 1'b1;
    end
    task automatic half_wait();
        repeat (HALF) @(posedge ref_clk);
        #2;
    endtask
    // Read data is taken at rising sck; an undriven line reads as z
    task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
        spi_csn = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            half_wait();
            spi_sck = 1'b0;
            spi_mosi = frame[i];
            half_wait();
            spi_sck = 1'b1;
            rd = {rd[6:0], spi_miso_oe ? spi_miso : 1'bz};
        end
        half_wait();
        spi_sck = 1'b0;
        half_wait();
        spi_csn = 1'b1;
        spi_mosi = ~spi_mosi;
        half_wait();
    endtask
endmodule

/* test_rx_serdes_status_data.sv */
// Self-checking bench for the receive status and channel A data block.
// Assumes rxs_top, the host model and the bound checker are compiled first.
`timescale 1ns/10ps
module test_rx_serdes_status_data;
    import rxs_pkg::*;
    logic             ref_clk, rst, rx_bit_clk, tx_enable, rx_enable;
    logic [1:0]       bvld, bdat, irq_pin_sel;
    logic [CNT_W-1:0] eof_len;
    logic [7:0]       rx_int_enable;
    logic             spi_sck, spi_csn, spi_mosi, spi_miso, spi_miso_oe, irq_out, irq_oe;
    int               miscompares, checks_done, pos[2], gap[2];
    bit               run[2], full[2], eof[2], flow[2], vall[2], unrd[2];
    logic [7:0]       acc[2], wr_rd;
    logic [7:0]       data_q[$];
    localparam longint WATCH_NS = 1_500_000;

    rxs_top rxs_top_i (.ref_clk(ref_clk), .rst(rst), .rx_bit_clk(rx_bit_clk),
        .chan_a_bit_valid(bvld[0]), .chan_a_bit_data(bdat[0]), .chan_b_bit_valid(bvld[1]),
        .chan_b_bit_data(bdat[1]), .eof_len(eof_len), .tx_enable(tx_enable),
        .rx_enable(rx_enable), .rx_int_enable(rx_int_enable), .irq_pin_sel(irq_pin_sel),
        .spi_sck(spi_sck), .spi_csn(spi_csn), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe), .irq_out(irq_out), .irq_oe(irq_oe));
    rxs_host rxs_host_i (.ref_clk(ref_clk), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .spi_sck(spi_sck), .spi_csn(spi_csn), .spi_mosi(spi_mosi));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        rx_bit_clk = 1'b0;
        #7;
        forever #62.5 rx_bit_clk = ~rx_bit_clk;
    end

    function automatic void load(int c, bit ok);
        if (unrd[c]) flow[c] = 1'b1;
        unrd[c] = 1'b1;
        full[c] = 1'b1;
        vall[c] = ok;
        if (c == 0) data_q.push_back(acc[c]);
        acc[c] = 8'h00;
        pos[c] = 0;
    endfunction
    function automatic void step(int c, bit v, bit d);
        if (v) begin
            acc[c][pos[c]] = d;
            pos[c]++;
            run[c] = 1'b1;
            gap[c] = 0;
            if (pos[c] == 8) load(c, 1'b1);
        end else if (run[c]) begin
            gap[c]++;
            if (gap[c] > eof_len) begin
                eof[c] = 1'b1;
                run[c] = 1'b0;
                if (pos[c] > 0) load(c, 1'b0);
            end
        end
    endfunction
    function automatic logic [7:0] stat();
        if (!(rx_enable && !tx_enable)) return 8'h00;
        return {vall[1], flow[1], eof[1], full[1], vall[0], flow[0], eof[0], full[0]};
    endfunction

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // Nine idle bit times after the pattern always close the frame
    task automatic frame(int c, logic [15:0] d, logic [15:0] m, int n);
        for (int i = 0; i < n + 9; i++) begin
            @(posedge rx_bit_clk);
            #2;
            bvld[c] = (i < n) && m[i];
            bdat[c] = (i < n) ? d[i] : ~bdat[c];
            step(c, bvld[c], bdat[c]);
        end
        repeat (2) @(posedge rx_bit_clk);
        repeat (10) @(posedge ref_clk);
        #2;
    endtask
    task automatic rreg(logic [5:0] a);
        logic [7:0] rd, ex;
        ex = 8'h00;
        if (a == ADDR_RX_STATUS) begin
            ex = stat();
            flow = '{1'b0, 1'b0};
            eof = '{1'b0, 1'b0};
        end else if (a == ADDR_RX_DATA_A) begin
            ex = data_q[$];
            if (!unrd[0]) flow[0] = 1'b1;
            unrd[0] = 1'b0;
            full[0] = 1'b0;
        end
        rxs_host_i.xfer({2'b00, a, 8'h00}, rd);
        check($sformatf("register %h", a), rd, ex);
    endtask
    task automatic irq_chk(logic [1:0] sel, logic [7:0] en);
        logic e;
        @(posedge ref_clk);
        #2;
        irq_pin_sel = sel;
        rx_int_enable = en;
        repeat (5) @(posedge ref_clk);
        #2;
        e = |(stat() & en & IRQ_SRC_MASK);
        check("irq", {7'h00, sel[1] ? irq_oe : irq_out == sel[0]}, {7'h00, e});
    endtask
    task automatic done(string s);
        $display("test %s finished", s);
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #(WATCH_NS);
        miscompares++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'h21A1));
        {rst, rx_enable, tx_enable, bvld, bdat, eof_len} = {3'b110, 4'h0, 3'h0};
        rx_int_enable = 8'h00;
        irq_pin_sel = 2'h1;
        data_q.push_back(RX_DATA_A_RST);
        repeat (3) @(posedge ref_clk);
        #2;
        rst = 1'b0;
        repeat (6) @(posedge ref_clk);
        #2;
        rreg(ADDR_RX_STATUS);
        rreg(ADDR_RX_DATA_A);
        rreg(ADDR_RX_STATUS);
        rreg(ADDR_RX_STATUS);
        rreg(6'h3F);
        done("reset");
        for (int k = 0; k < 8; k++) begin
            eof_len = 3'($urandom);
            frame(k % 2, 16'($urandom), 16'hFFFF, 8 * (1 + (k / 2) % 2));
            irq_chk(2'(k), 8'($urandom));
            rreg(ADDR_RX_STATUS);
            irq_chk(2'h1, 8'h88);
            rreg(ADDR_RX_DATA_A);
        end
        done("bytes");
        for (int g = 0; g < 3; g++) begin
            eof_len = 3'(g);
            frame(0, 16'($urandom), 16'h0077, 7);
            rreg(ADDR_RX_STATUS);
            rreg(ADDR_RX_DATA_A);
        end
        done("frame end");
        for (int m = 0; m < 4; m++) begin
            frame(0, 16'($urandom), 16'h0FFF, 12);
            {tx_enable, rx_enable} = 2'(m);
            irq_chk(2'h1, 8'hFF);
            rreg(ADDR_RX_STATUS);
            {tx_enable, rx_enable} = 2'b01;
            rreg(ADDR_RX_STATUS);
        end
        done("mode");
        frame(0, 16'($urandom), 16'hFFFF, 8);
        rxs_host_i.xfer({2'b10, ADDR_RX_STATUS, 8'hFF}, wr_rd);
        rxs_host_i.xfer({2'b10, ADDR_RX_DATA_A, 8'h5A}, wr_rd);
        rreg(ADDR_RX_STATUS);
        rreg(ADDR_RX_DATA_A);
        done("writes");
        print_verdict();
    end
endmodule
